// ===== verilog/cmp_pkg.sv
// Package: constants, register map and carrier types for the comparator event control
// ==========================================================================
// Summary of operation
// - Flag sets when a comparator output event matches the selected edge mode.
// - Interrupt request needs flag set, enable bit one and global enable set.
// - Flag clears by hardware when the processor executes the comparator vector.
// - Writing one to the flag clears it; writing zero leaves it unchanged.
// - With enable bit zero no interrupt is raised, though the flag still sets.
// - Capture-routing bit one feeds comparator output to the timer capture front end.
// - Capture-routing bit zero keeps comparator output away from the timer capture.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Mux enabled and converter off: channel field picks converter pin 0 to 7.
// - Mux disabled or converter on: dedicated negative pin drives the negative input.
// - Buffer disable bits turn off pin input buffers; the pin bit reads zero.
// - Output status bit passes a synchronizer, one to two cycles of delay.
// - Power-off bit one switches comparator power off.
// ==========================================================================
package cmp_pkg;

    // ======================================================================
    // Register byte addresses
    localparam logic [3:0] CTRL_STATUS_ADDR  = 4'h0;  // comparator_control_status
    localparam logic [3:0] BUF_DISABLE_ADDR  = 4'h4;  // pin_input_buffer_disable
    localparam logic [3:0] MUX_CTRL_ADDR     = 4'h8;  // mux enable and channel field

    // ======================================================================
    // Field positions of comparator_control_status
    localparam int POWER_OFF_BIT    = 7;
    localparam int OUT_STATUS_BIT   = 5;
    localparam int IRQ_FLAG_BIT     = 4;
    localparam int IRQ_ENABLE_BIT   = 3;
    localparam int CAPTURE_BIT      = 2;
    localparam int MODE_HI_BIT      = 1;
    localparam int MODE_LO_BIT      = 0;

    // Field positions of pin_input_buffer_disable
    localparam int NEG_BUF_OFF_BIT  = 1;
    localparam int POS_BUF_OFF_BIT  = 0;

    // Field positions of the mux control register
    localparam int MUX_ENABLE_BIT   = 3;
    localparam int CHAN_LSB         = 0;
    localparam int CHAN_W           = 3;

    // ======================================================================
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET  = 8'h00;
    localparam logic [7:0] MUX_RESET  = 8'h00;

    // Synchronizer depth
    localparam int SYNC_STAGES = 2;

    // Interrupt mode encodings
    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALLING  = 2'b10,
        MODE_RISING   = 2'b11
    } irq_mode_t;

    // Pin digital inputs as seen after buffer gating
    typedef struct packed {
        logic neg_input_pin;
        logic pos_input_pin;
    } pin_pair_t;

    // Analog core steering
    typedef struct packed {
        logic       cmp_power_off;
        logic       neg_use_channel;
        logic [2:0] channel_select_field;
    } analog_ctrl_t;

endpackage : cmp_pkg

// ===== verilog/cmp_sync.sv
// Two-stage synchronizer for the raw comparator result
`timescale 1ns/1ps
module cmp_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    // ======================================================================
    // Shift chain; only the last stage is read outside
    logic [STAGES-1:0] chain_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain_ff[STAGES-1];
endmodule : cmp_sync

// ===== verilog/cmp_edge_detect.sv
// Edge qualifier for comparator output events
`timescale 1ns/1ps
module cmp_edge_detect (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              level_i,
    input  cmp_pkg::irq_mode_t     mode_i,
    output logic                   event_o
);
    import cmp_pkg::*;

    // ======================================================================
    // Previous synchronized level
    logic prev_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_i;
        end
    end

    // Mode-qualified event, one cycle per transition
    always_comb begin
        case (mode_i)
            MODE_TOGGLE:  event_o = level_i ^ prev_ff;
            MODE_FALLING: event_o = prev_ff & ~level_i;
            MODE_RISING:  event_o = ~prev_ff & level_i;
            default:      event_o = 1'b0;                    // Reserved mode
        endcase
    end
endmodule : cmp_edge_detect

// ===== verilog/comparator_event_control.sv
// Top level: Wishbone register file and comparator event control
`timescale 1ns/1ps
module comparator_event_control (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Processor side
    input  wire logic                  global_irq_enable_i,
    input  wire logic                  irq_vector_ack_i,
    output logic                       cmp_irq_o,
    // Converter state
    input  wire logic                  converter_enable_i,
    // Analog core
    input  wire logic                  cmp_raw_i,
    output cmp_pkg::analog_ctrl_t      analog_ctrl_o,
    // Pins
    input  cmp_pkg::pin_pair_t         pin_raw_i,
    output cmp_pkg::pin_pair_t         pin_read_o,
    output logic [1:0]                 pin_buffer_off_o,
    // Timer capture front end
    output logic                       capture_src_o,
    output logic                       capture_src_valid_o
);
    import cmp_pkg::*;

    // ======================================================================
    // Register state
    logic                  power_off_ff;
    logic                  irq_flag_ff;
    logic                  irq_enable_ff;
    logic                  capture_ff;
    irq_mode_t             mode_ff;
    logic                  neg_buf_off_ff;
    logic                  pos_buf_off_ff;
    logic                  mux_enable_ff;
    logic [CHAN_W-1:0]     chan_ff;
    logic                  ack_ff;
    logic                  err_ff;
    logic [31:0]           rdata_ff;

    // Derived signals
    logic                  cmp_sync;
    logic                  cmp_event;
    logic                  bus_req;
    logic                  wr_lane0;
    logic                  is_mapped;
    logic [7:0]            nxt_rdata;

    // ======================================================================
    // Address decode helper
    function automatic logic addr_mapped(input logic [3:0] adr);
        addr_mapped = (adr == CTRL_STATUS_ADDR) || (adr == BUF_DISABLE_ADDR) ||
                      (adr == MUX_CTRL_ADDR);
    endfunction : addr_mapped

    // ======================================================================
    // Comparator output synchronizer
    cmp_sync #(
        .STAGES  (SYNC_STAGES)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cmp_raw_i),
        .sync_o  (cmp_sync)
    );

    // Edge detection by selected mode
    cmp_edge_detect u_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (cmp_sync),
        .mode_i  (mode_ff),
        .event_o (cmp_event)
    );

    // ======================================================================
    // Bus request qualification; one access per request, ack drops after one cycle
    assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    assign is_mapped = addr_mapped(wb_adr_i);
    assign wr_lane0  = bus_req & wb_we_i & wb_sel_i[0] & is_mapped;

    // Acknowledge or error, one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req & is_mapped;
            err_ff <= bus_req & ~is_mapped;
        end
    end

    // ======================================================================
    // Control and status register bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_off_ff  <= CTRL_RESET[POWER_OFF_BIT];
            irq_enable_ff <= CTRL_RESET[IRQ_ENABLE_BIT];
            capture_ff    <= CTRL_RESET[CAPTURE_BIT];
            mode_ff       <= irq_mode_t'(CTRL_RESET[MODE_HI_BIT:MODE_LO_BIT]);
        end else if (wr_lane0 && wb_adr_i == CTRL_STATUS_ADDR) begin
            power_off_ff  <= wb_dat_i[POWER_OFF_BIT];
            irq_enable_ff <= wb_dat_i[IRQ_ENABLE_BIT];
            capture_ff    <= wb_dat_i[CAPTURE_BIT];
            mode_ff       <= irq_mode_t'(wb_dat_i[MODE_HI_BIT:MODE_LO_BIT]);
        end
    end

    // Interrupt flag: hardware set wins over any clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flag_ff <= CTRL_RESET[IRQ_FLAG_BIT];
        end else if (cmp_event) begin
            irq_flag_ff <= 1'b1;
        end else if (irq_vector_ack_i && cmp_irq_o) begin
            irq_flag_ff <= 1'b0;
        end else if (wr_lane0 && wb_adr_i == CTRL_STATUS_ADDR &&
                     wb_dat_i[IRQ_FLAG_BIT]) begin
            irq_flag_ff <= 1'b0;
        end
    end

    // Buffer disable bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            neg_buf_off_ff <= BUF_RESET[NEG_BUF_OFF_BIT];
            pos_buf_off_ff <= BUF_RESET[POS_BUF_OFF_BIT];
        end else if (wr_lane0 && wb_adr_i == BUF_DISABLE_ADDR) begin
            neg_buf_off_ff <= wb_dat_i[NEG_BUF_OFF_BIT];
            pos_buf_off_ff <= wb_dat_i[POS_BUF_OFF_BIT];
        end
    end

    // Negative input mux control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_enable_ff <= MUX_RESET[MUX_ENABLE_BIT];
            chan_ff       <= MUX_RESET[CHAN_LSB +: CHAN_W];
        end else if (wr_lane0 && wb_adr_i == MUX_CTRL_ADDR) begin
            mux_enable_ff <= wb_dat_i[MUX_ENABLE_BIT];
            chan_ff       <= wb_dat_i[CHAN_LSB +: CHAN_W];
        end
    end

    // ======================================================================
    // Read data mux; unused bits read zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (wb_adr_i)
            CTRL_STATUS_ADDR: begin
                nxt_rdata[POWER_OFF_BIT]  = power_off_ff;
                nxt_rdata[OUT_STATUS_BIT] = cmp_sync;
                nxt_rdata[IRQ_FLAG_BIT]   = irq_flag_ff;
                nxt_rdata[IRQ_ENABLE_BIT] = irq_enable_ff;
                nxt_rdata[CAPTURE_BIT]    = capture_ff;
                nxt_rdata[MODE_HI_BIT:MODE_LO_BIT] = mode_ff;
            end
            BUF_DISABLE_ADDR: begin
                nxt_rdata[NEG_BUF_OFF_BIT] = neg_buf_off_ff;
                nxt_rdata[POS_BUF_OFF_BIT] = pos_buf_off_ff;
            end
            MUX_CTRL_ADDR: begin
                nxt_rdata[MUX_ENABLE_BIT]      = mux_enable_ff;
                nxt_rdata[CHAN_LSB +: CHAN_W]  = chan_ff;
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data register, captured with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req) begin
            rdata_ff <= {24'h00_0000, nxt_rdata};
        end
    end

    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;

    // ======================================================================
    // Interrupt request to the processor
    assign cmp_irq_o = irq_flag_ff & irq_enable_ff & global_irq_enable_i;

    // Timer capture routing; disconnected path holds low
    assign capture_src_o       = capture_ff & cmp_sync;
    assign capture_src_valid_o = capture_ff;

    // Analog steering: mux only when enabled and converter is off
    assign analog_ctrl_o.cmp_power_off        = power_off_ff;
    assign analog_ctrl_o.neg_use_channel      = mux_enable_ff & ~converter_enable_i;
    assign analog_ctrl_o.channel_select_field = chan_ff;

    // Pin input buffers; gated pins read zero
    assign pin_buffer_off_o         = {neg_buf_off_ff, pos_buf_off_ff};
    assign pin_read_o.neg_input_pin = pin_raw_i.neg_input_pin & ~neg_buf_off_ff;
    assign pin_read_o.pos_input_pin = pin_raw_i.pos_input_pin & ~pos_buf_off_ff;

endmodule : comparator_event_control

// ===== dv/cmp_event_props.sv
// Port checks for the comparator event control block
`timescale 1ns/1ps
module cmp_event_props (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [3:0]      wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire logic            wb_err_o,
    input wire logic            global_irq_enable_i,
    input wire logic            irq_vector_ack_i,
    input wire logic            cmp_irq_o,
    input wire logic            converter_enable_i,
    input wire logic            cmp_raw_i,
    input cmp_pkg::analog_ctrl_t analog_ctrl_o,
    input cmp_pkg::pin_pair_t   pin_raw_i,
    input cmp_pkg::pin_pair_t   pin_read_o,
    input wire logic [1:0]      pin_buffer_off_o,
    input wire logic            capture_src_o,
    input wire logic            capture_src_valid_o
);
    import cmp_pkg::*;
    // ==========================================
    // Bus, interrupt, pin and capture relations
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bus_answer:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered in one cycle");
    a_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_err_single:
        assert property (wb_err_o |=> !wb_err_o) else $error("err longer than one cycle");
    a_read_upper:
        assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_irq_global:
        assert property (cmp_irq_o |-> global_irq_enable_i) else $error("irq without global enable");
    a_capture_off:
        assert property (!capture_src_valid_o |-> !capture_src_o) else $error("capture leaks");
    a_pin_gate:
        assert property (pin_read_o == (pin_raw_i & ~pin_buffer_off_o)) else $error("pin gating");
    a_conv_wins:
        assert property (converter_enable_i |-> !analog_ctrl_o.neg_use_channel)
        else $error("channel used with converter on");
    a_reset_clear:
        assert property ($fell(rst_i) |-> !cmp_irq_o && !capture_src_valid_o)
        else $error("outputs not cleared by reset");
    // Main scenarios reached
    c_irq: cover property (cmp_irq_o);
    c_capture: cover property (capture_src_o);
    c_err: cover property (wb_err_o);
endmodule : cmp_event_props

// ===== dv/cmp_analog_model.sv
// Behavioural analog comparator core on the far side of the block
`timescale 1ns/1ps
module cmp_analog_model (
    input  cmp_pkg::analog_ctrl_t ctrl_i,
    input  wire logic [7:0]       pos_v_i,
    input  wire logic [7:0]       neg_v_i,
    input  wire logic [63:0]      chan_v_i,
    output logic                  raw_o
);
    import cmp_pkg::*;
    logic [7:0] neg_sel;
    // Negative input from a channel pin or the dedicated pin
    assign neg_sel = ctrl_i.neg_use_channel ? chan_v_i[{ctrl_i.channel_select_field, 3'b000} +: 8]
                                            : neg_v_i;
    // Unpowered core holds its result low
    assign raw_o = !ctrl_i.cmp_power_off && (pos_v_i > neg_sel);
endmodule : cmp_analog_model

// ===== dv/comparator_event_control_tb.sv
// Self-checking testbench for the comparator event control block
`timescale 1ns/1ps
module comparator_event_control_tb;
    import cmp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic gie = 1'b0, vec = 1'b0, conv = 1'b0, raw, ack, err, irq, cap, cap_v, e;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rd_dat;
    logic [7:0] pos_v = 8'h32, neg_v = 8'h64, q;
    logic [63:0] chan_v = 64'h0;
    logic [1:0] boff, m;
    analog_ctrl_t actl;
    pin_pair_t pin_raw = 2'b00, pin_rd;
    logic [3:0] sel = 4'hF;
    logic tmr_ie = 1'b0, tmr_irq;
    // Timer side: a routed capture interrupts only with its own capture enable set
    assign tmr_irq = cap & tmr_ie;
    int failures = 0, n_tests = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    comparator_event_control i_comparator_event_control (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rd_dat), .wb_ack_o(ack), .wb_err_o(err),
        .global_irq_enable_i(gie), .irq_vector_ack_i(vec), .cmp_irq_o(irq),
        .converter_enable_i(conv), .cmp_raw_i(raw), .analog_ctrl_o(actl), .pin_raw_i(pin_raw),
        .pin_read_o(pin_rd), .pin_buffer_off_o(boff), .capture_src_o(cap),
        .capture_src_valid_o(cap_v));
    cmp_analog_model i_cmp_analog_model (.ctrl_i(actl), .pos_v_i(pos_v), .neg_v_i(neg_v),
        .chan_v_i(chan_v), .raw_o(raw));
    // ==========================================
    // Verdict, compare and bus tasks
    task end_sim;
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task chk(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_i); while (!(ack || err));
        q = rd_dat[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(q, x);
    endtask : rd
    task level(input logic [7:0] v);
        @(posedge clk_i);
        pos_v <= v;
        repeat (6) @(posedge clk_i);
    endtask : level
    // Cycle ceiling against hangs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_sim;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL_STATUS_ADDR, 8'h00);
        rd(BUF_DISABLE_ADDR, 8'h00);
        rd(MUX_CTRL_ADDR, 8'h00);
        bus(1'b0, 4'hC, 8'h00);
        chk({e, q[6:0]}, 8'h80);
        pin_raw <= 2'b11;
        wr(BUF_DISABLE_ADDR, 8'h03);
        rd(BUF_DISABLE_ADDR, 8'h03);
        chk({6'h0, pin_rd}, 8'h00);
        wr(BUF_DISABLE_ADDR, 8'h01);
        chk({6'h0, pin_rd}, 8'h02);
        chk({6'h0, boff}, 8'h01);
        // A write without the low byte lane selected is ignored
        sel <= 4'hE;
        wr(BUF_DISABLE_ADDR, 8'h00);
        sel <= 4'hF;
        rd(BUF_DISABLE_ADDR, 8'h01);
        // Each mode against a rise then a fall
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 2'b00 : (i == 1) ? 2'b10 : (i == 2) ? 2'b11 : 2'b01;
            wr(CTRL_STATUS_ADDR, {6'h00, m});
            wr(CTRL_STATUS_ADDR, {6'h04, m});
            level(8'hFA);
            rd(CTRL_STATUS_ADDR, {3'b001, m == 2'b00 || m == 2'b11, 2'b00, m});
            chk({7'h0, cap}, 8'h00);
            wr(CTRL_STATUS_ADDR, {6'h00, m});
            rd(CTRL_STATUS_ADDR, {3'b001, m == 2'b00 || m == 2'b11, 2'b00, m});
            wr(CTRL_STATUS_ADDR, {6'h04, m});
            rd(CTRL_STATUS_ADDR, {6'h08, m});
            level(8'h32);
            rd(CTRL_STATUS_ADDR, {3'b000, m == 2'b00 || m == 2'b10, 2'b00, m});
            wr(CTRL_STATUS_ADDR, {6'h04, m});
        end
        // Interrupt gating and vector clear
        wr(CTRL_STATUS_ADDR, 8'h08);
        level(8'hFA);
        chk({7'h0, irq}, 8'h00);
        gie <= 1'b1;
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h01);
        wr(CTRL_STATUS_ADDR, 8'h00);
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h00);
        rd(CTRL_STATUS_ADDR, 8'h30);
        wr(CTRL_STATUS_ADDR, 8'h08);
        vec <= 1'b1;
        @(posedge clk_i);
        vec <= 1'b0;
        rd(CTRL_STATUS_ADDR, 8'h28);
        // Capture routing
        wr(CTRL_STATUS_ADDR, 8'h04);
        level(8'h32);
        chk({6'h0, cap_v, cap}, 8'h02);
        level(8'hFA);
        chk({6'h0, cap_v, cap}, 8'h03);
        chk({7'h0, tmr_irq}, 8'h00);
        tmr_ie <= 1'b1;
        @(negedge clk_i);
        chk({7'h0, tmr_irq}, 8'h01);
        wr(CTRL_STATUS_ADDR, 8'h00);
        @(negedge clk_i);
        chk({6'h0, cap_v, cap}, 8'h00);
        // Channel pick for the negative input
        for (int c = 0; c < 8; c++) begin
            chan_v <= 64'hFF << (c * 8);
            wr(MUX_CTRL_ADDR, {5'b00001, c[2:0]});
            repeat (6) @(posedge clk_i);
            bus(1'b0, CTRL_STATUS_ADDR, 8'h00);
            chk({7'h0, q[5]}, 8'h00);
            chk({3'h0, actl}, {5'h01, c[2:0]});
        end
        conv <= 1'b1;
        repeat (6) @(posedge clk_i);
        bus(1'b0, CTRL_STATUS_ADDR, 8'h00);
        chk({7'h0, q[5]}, 8'h01);
        conv <= 1'b0;
        wr(MUX_CTRL_ADDR, 8'h07);
        repeat (6) @(posedge clk_i);
        bus(1'b0, CTRL_STATUS_ADDR, 8'h00);
        chk({7'h0, q[5]}, 8'h01);
        // Power off drops the result
        wr(CTRL_STATUS_ADDR, 8'h90);
        repeat (6) @(posedge clk_i);
        rd(CTRL_STATUS_ADDR, 8'h90);
        chk({7'h0, actl.cmp_power_off}, 8'h01);
        end_sim;
    end
endmodule : comparator_event_control_tb
bind comparator_event_control cmp_event_props i_cmp_event_props (.*);
